//--- verilog/wepl_consts.vh
// Constants for the wake-event and power-loss register slice.
// Assumes a 32-bit AHB-Lite slave port, one aligned word per register.
`ifndef WEPL_CONSTS_VH
`define WEPL_CONSTS_VH

// Register indexes and their byte addresses (index times four)
`define WEPL_IDX_KEY_INDEX   8'he1
`define WEPL_IDX_KEY_DATA    8'he2
`define WEPL_IDX_STATUS      8'he3
`define WEPL_IDX_CONTROL     8'he4
`define WEPL_IDX_LAST_STATE  8'he6
`define WEPL_ADDR_KEY_INDEX  32'h0000_0384
`define WEPL_ADDR_KEY_DATA   32'h0000_0388
`define WEPL_ADDR_STATUS     32'h0000_038c
`define WEPL_ADDR_CONTROL    32'h0000_0390
`define WEPL_ADDR_LAST_STATE 32'h0000_0398

// Reset values
`define WEPL_RST_KEY_DATA    8'hff
`define WEPL_RST_STATUS      8'h08
`define WEPL_RST_CONTROL     8'h00
`define WEPL_RST_KEY_INDEX   8'h00

// Status bit positions
`define WEPL_ST_KBD          0
`define WEPL_ST_MOUSE        1
`define WEPL_ST_PSW          2
`define WEPL_ST_THERM        3
`define WEPL_ST_LOSS         4
`define WEPL_ST_STBY         5

// Control and last-state bit positions
`define WEPL_CT_LOSS_RPT     7
`define WEPL_CT_REC_HI       6
`define WEPL_CT_REC_LO       5
`define WEPL_CT_ANY_KEY      3
`define WEPL_CT_HUNT         2
`define WEPL_LS_LAST_OFF     4

// Recovery field encodings
`define WEPL_REC_OFF         2'h0
`define WEPL_REC_ON          2'h1
`define WEPL_REC_PRIOR       2'h2
`define WEPL_REC_USER        2'h3

// Key window layout: set codes in index bits 7..4, last slot per set
`define WEPL_KEY_LAST_OFS    4'he
`define WEPL_CAPTURE_SLOT    2'h1

`endif

//--- verilog/wepl_key_mem.v
// Key-combination store: 64 bytes, two write ports, registered read.
// Assumes the two write ports never target the same byte in a cycle.
`timescale 1ns/10ps
`include "wepl_consts.vh"
module wepl_key_mem (
    input  wire       core_clk_in,
    input  wire       sys_rst_in,
    input  wire [5:0] rd_addr_in,
    input  wire       rd_ok_in,
    output reg  [7:0] rd_data_out,
    input  wire       a_we_in,
    input  wire [5:0] a_addr_in,
    input  wire [7:0] a_data_in,
    input  wire       b_we_in,
    input  wire [5:0] b_addr_in,
    input  wire [7:0] b_data_in
);
    reg [7:0]  mem [0:63];
    reg [63:0] written;

    // Unwritten bytes read as erased; avoids resetting the whole array
    always @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            written     <= 64'h0;
            rd_data_out <= `WEPL_RST_KEY_DATA;
        end else begin
            if (a_we_in) begin
                mem[a_addr_in]     <= a_data_in;
                written[a_addr_in] <= 1'b1;
            end
            if (b_we_in) begin
                mem[b_addr_in]     <= b_data_in;
                written[b_addr_in] <= 1'b1;
            end
            if (rd_ok_in && written[rd_addr_in])
                rd_data_out <= mem[rd_addr_in];
            else
                rd_data_out <= `WEPL_RST_KEY_DATA;
        end
    end
endmodule

//--- verilog/wepl_ctrl.v
// Wake-event status, power-loss recovery and wake-key window registers.
// Assumes an AHB-Lite master on core_clk_in; event inputs are async pins.
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/10ps
`include "wepl_consts.vh"

// How it works
// [R1] Byte window reads and writes the key character chosen by the index; captured keys at 10h are read-only.
// [R2] Key window reads FFh after reset; contents kept on standby power.
// [R3] Status resets to 08h; bits 7 and 6 read zero.
// [R4] Bit 3 set by thermal shutdown event; read-only, cleared by read.
// [R5] Bit 2 set by power-switch event; read-only, cleared by read.
// [R6] Bit 1 latches on mouse wake event, holds until read, then clears.
// [R7] Bit 0 latches on keyboard wake event, holds until read, then clears.
// [R8] With control bit 7 set, bit 4 shows post-loss state; else zero.
// [R9] Bits 6..5 pick recovery: off, on, prior state, or last-state flag.
// [R10] Recovery field lives in the battery domain, only power-on reset clears.
// [R11] Control bit 3 picks any key or programmed keys; host reset clears.
// [R12] Bit 2 enables hunting; cleared by captured wake or host reset.
// [R13] Control resets to 00h; bits 7, 4, 1, 0 read zero.
// [R14] Index reaches sets at 00h, 30h, 40h; captured keys at 10h.
// [R15] Battery-backed last-state flag supplies the state for setting 11.
// [R16] Status read returns flags then clears; same-cycle event stays set.
module wepl_ctrl (
    input  wire        core_clk_in,
    input  wire        sys_rst_in,
    input  wire        hsel_in,
    input  wire [31:0] haddr_in,
    input  wire [1:0]  htrans_in,
    input  wire        hwrite_in,
    input  wire [2:0]  hsize_in,
    input  wire [31:0] hwdata_in,
    input  wire        hready_in,
    output reg  [31:0] hrdata_out,
    output reg         hreadyout_out,
    output reg         hresp_out,
    input  wire        host_bus_reset_n_in,
    input  wire        thermal_shutdown_in,
    input  wire        power_switch_input_in,
    input  wire        mouse_wake_in,
    input  wire        keyboard_wake_in,
    input  wire        standby_supply_event_in,
    input  wire        power_return_in,
    input  wire        prior_state_off_in,
    input  wire        key_capture_valid_in,
    input  wire [7:0]  key_capture_data_in,
    output reg         power_on_req_out,
    output reg         kb_wake_any_key_out,
    output reg         hunt_enable_out
);
    // Register select codes
    localparam [2:0] SEL_NONE  = 3'h0;
    localparam [2:0] SEL_INDEX = 3'h1;
    localparam [2:0] SEL_DATA  = 3'h2;
    localparam [2:0] SEL_STAT  = 3'h3;
    localparam [2:0] SEL_CTRL  = 3'h4;
    localparam [2:0] SEL_LAST  = 3'h5;

    // Bus slave states
    localparam [0:0] ST_IDLE = 1'b0;
    localparam [0:0] ST_DATA = 1'b1;

    // Pin vector positions
    localparam P_KBD   = 0;
    localparam P_MOUSE = 1;
    localparam P_PSW   = 2;
    localparam P_THERM = 3;
    localparam P_STBY  = 4;
    localparam P_RET   = 5;
    localparam P_PRIOR = 6;

    // Reset image; only the six low flags are stored, bits 7..6 read zero
    localparam [7:0] STATUS_RESET = `WEPL_RST_STATUS;

    reg  [6:0] pin_meta;
    reg  [6:0] pin_sync;
    reg  [6:0] pin_prev;
    reg        hbr_meta;
    reg        hbr_sync;
    reg  [0:0] bus_state;
    reg  [2:0] data_sel;
    reg        data_write;
    reg  [7:0] key_index;
    reg  [5:0] status_flags;
    reg  [1:0] recovery_sel;
    reg        loss_report_en;
    reg        last_state_flag;
    reg  [3:0] capture_ptr;
    reg  [5:0] next_status;
    reg  [7:0] status_view;
    reg  [7:0] control_view;
    reg  [7:0] read_mux;
    reg        recover_off;

    wire [6:0] pin_rise;
    wire       host_bus_rst;
    wire       bus_take;
    wire       in_data;
    wire       wr_now;
    wire       rd_now;
    wire       status_clear;
    wire       wake_seen;
    wire [6:0] key_map;
    wire [7:0] key_rd_data;
    wire       key_bus_we;

    // Select code for a full byte address; anything else is unmapped
    function [2:0] reg_select;
        input [31:0] addr;
        begin
            case (addr)
                `WEPL_ADDR_KEY_INDEX:  reg_select = SEL_INDEX;
                `WEPL_ADDR_KEY_DATA:   reg_select = SEL_DATA;
                `WEPL_ADDR_STATUS:     reg_select = SEL_STAT;
                `WEPL_ADDR_CONTROL:    reg_select = SEL_CTRL;
                `WEPL_ADDR_LAST_STATE: reg_select = SEL_LAST;
                default:               reg_select = SEL_NONE;
            endcase
        end
    endfunction

    // Index to {valid, slot, offset}; gaps and the 0Fh slots are holes
    function [6:0] key_slot;
        input [7:0] idx;
        reg   [1:0] slot;
        reg         ok;
        begin
            slot = 2'h0;
            ok   = (idx[3:0] <= `WEPL_KEY_LAST_OFS);
            case (idx[7:4])
                4'h0:    slot = 2'h0;
                4'h1:    slot = 2'h1;
                4'h3:    slot = 2'h2;
                4'h4:    slot = 2'h3;
                default: ok = 1'b0;
            endcase
            key_slot = {ok, slot, idx[3:0]};
        end
    endfunction

    // Two-flop synchronisers, then one more stage for edge detection
    always @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            pin_meta <= 7'h00;
            pin_sync <= 7'h00;
            pin_prev <= 7'h00;
            hbr_meta <= 1'b1;
            hbr_sync <= 1'b1;
        end else begin
            pin_meta <= {prior_state_off_in, power_return_in,
                         standby_supply_event_in, thermal_shutdown_in,
                         power_switch_input_in, mouse_wake_in,
                         keyboard_wake_in};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
            hbr_meta <= host_bus_reset_n_in;
            hbr_sync <= hbr_meta;
        end
    end

    assign pin_rise     = pin_sync & ~pin_prev;
    assign host_bus_rst = ~hbr_sync;
    assign wake_seen    = pin_rise[P_KBD] | pin_rise[P_MOUSE] | pin_rise[P_PSW];

    // Bus handshake terms
    assign bus_take     = hsel_in & htrans_in[1] & hready_in;
    assign in_data      = (bus_state == ST_DATA);
    assign wr_now       = in_data & data_write;
    assign rd_now       = in_data & ~data_write;
    assign status_clear = rd_now & (data_sel == SEL_STAT); // [R16]

    // AHB-Lite slave: one wait state on every access, always OKAY
    always @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            bus_state     <= ST_IDLE;
            data_sel      <= SEL_NONE;
            data_write    <= 1'b0;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
            hrdata_out    <= 32'h0000_0000;
        end else begin
            hresp_out <= 1'b0;
            case (bus_state)
                ST_IDLE: begin
                    if (bus_take) begin
                        bus_state     <= ST_DATA;
                        data_sel      <= reg_select(haddr_in);
                        data_write    <= hwrite_in;
                        hreadyout_out <= 1'b0;
                    end
                end
                ST_DATA: begin
                    bus_state     <= ST_IDLE;
                    hreadyout_out <= 1'b1;
                    if (!data_write)
                        hrdata_out <= {24'h00_0000, read_mux};
                end
                default: begin
                    bus_state     <= ST_IDLE;
                    hreadyout_out <= 1'b1;
                end
            endcase
        end
    end

    // Read views; reserved bits forced low
    always @* begin
        status_view = 8'h00;                                           // [R3]
        status_view[`WEPL_ST_STBY]  = status_flags[`WEPL_ST_STBY];
        status_view[`WEPL_ST_LOSS]  = status_flags[`WEPL_ST_LOSS] & loss_report_en; // [R8]
        status_view[`WEPL_ST_THERM] = status_flags[`WEPL_ST_THERM];
        status_view[`WEPL_ST_PSW]   = status_flags[`WEPL_ST_PSW];
        status_view[`WEPL_ST_MOUSE] = status_flags[`WEPL_ST_MOUSE];
        status_view[`WEPL_ST_KBD]   = status_flags[`WEPL_ST_KBD];
        control_view = 8'h00;                                          // [R13]
        control_view[`WEPL_CT_REC_HI:`WEPL_CT_REC_LO] = recovery_sel;
        control_view[`WEPL_CT_ANY_KEY] = kb_wake_any_key_out;
        control_view[`WEPL_CT_HUNT]    = hunt_enable_out;
        case (data_sel)
            SEL_INDEX: read_mux = key_index;
            SEL_DATA:  read_mux = key_rd_data;                         // [R1]
            SEL_STAT:  read_mux = status_view;
            SEL_CTRL:  read_mux = control_view;
            SEL_LAST:  read_mux = {3'h0, last_state_flag, 4'h0};
            default:   read_mux = 8'h00;
        endcase
    end

    // Sticky event flags: new events win over a same-cycle read clear
    always @* begin
        next_status = status_flags;
        if (status_clear)
            next_status = 6'h00;                                      // [R16]
        if (pin_rise[P_THERM])
            next_status[`WEPL_ST_THERM] = 1'b1;                        // [R4]
        if (pin_rise[P_PSW])
            next_status[`WEPL_ST_PSW] = 1'b1;                          // [R5]
        if (pin_rise[P_MOUSE])
            next_status[`WEPL_ST_MOUSE] = 1'b1;                        // [R6]
        if (pin_rise[P_KBD])
            next_status[`WEPL_ST_KBD] = 1'b1;                          // [R7]
        if (pin_rise[P_STBY])
            next_status[`WEPL_ST_STBY] = 1'b1;
        if (pin_rise[P_RET] && recover_off)
            next_status[`WEPL_ST_LOSS] = 1'b1;                         // [R8]
    end

    always @(posedge core_clk_in) begin
        if (sys_rst_in)
            status_flags <= STATUS_RESET[5:0];                         // [R3]
        else
            status_flags <= next_status;
    end

    // Recovery decision on return from power loss
    always @* begin
        case (recovery_sel)
            `WEPL_REC_OFF:   recover_off = 1'b1;                       // [R9]
            `WEPL_REC_ON:    recover_off = 1'b0;
            `WEPL_REC_PRIOR: recover_off = pin_sync[P_PRIOR];
            `WEPL_REC_USER:  recover_off = last_state_flag;            // [R15]
            default:         recover_off = 1'b1;
        endcase
    end

    always @(posedge core_clk_in) begin
        if (sys_rst_in)
            power_on_req_out <= 1'b0;
        else
            power_on_req_out <= pin_rise[P_RET] & ~recover_off;        // [R9]
    end

    // Battery-domain controls: only the power-on reset clears them
    always @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            recovery_sel    <= `WEPL_REC_OFF;                          // [R10]
            loss_report_en  <= 1'b0;
            last_state_flag <= 1'b0;
        end else if (wr_now) begin
            if (data_sel == SEL_CTRL) begin
                recovery_sel   <= hwdata_in[`WEPL_CT_REC_HI:`WEPL_CT_REC_LO]; // [R9]
                loss_report_en <= hwdata_in[`WEPL_CT_LOSS_RPT];        // [R8]
            end
            if (data_sel == SEL_LAST)
                last_state_flag <= hwdata_in[`WEPL_LS_LAST_OFF];       // [R15]
        end
    end

    // Host-bus-reset domain controls
    always @(posedge core_clk_in) begin
        if (sys_rst_in || host_bus_rst) begin
            kb_wake_any_key_out <= 1'b0;                               // [R11]
            hunt_enable_out     <= 1'b0;                               // [R12]
        end else begin
            if (wr_now && data_sel == SEL_CTRL)
                kb_wake_any_key_out <= hwdata_in[`WEPL_CT_ANY_KEY];    // [R11]
            // A captured wake beats a same-cycle enable write
            if (wake_seen)
                hunt_enable_out <= 1'b0;                               // [R12]
            else if (wr_now && data_sel == SEL_CTRL)
                hunt_enable_out <= hwdata_in[`WEPL_CT_HUNT];
        end
    end

    // Wake-key index; standby domain, so only power-on reset clears it
    always @(posedge core_clk_in) begin
        if (sys_rst_in)
            key_index <= `WEPL_RST_KEY_INDEX;
        else if (wr_now && data_sel == SEL_INDEX)
            key_index <= hwdata_in[7:0];
    end

    // Incoming keys fill the capture area in a ring of fifteen bytes
    always @(posedge core_clk_in) begin
        if (sys_rst_in)
            capture_ptr <= 4'h0;
        else if (key_capture_valid_in) begin
            if (capture_ptr == `WEPL_KEY_LAST_OFS)
                capture_ptr <= 4'h0;
            else
                capture_ptr <= capture_ptr + 4'h1;
        end
    end

    // Capture area is read-only to the bus, so write ports never collide
    assign key_map    = key_slot(key_index);                           // [R14]
    assign key_bus_we = wr_now & (data_sel == SEL_DATA) & key_map[6] &
                        (key_map[5:4] != `WEPL_CAPTURE_SLOT);          // [R1]

    wepl_key_mem u_key_mem (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .rd_addr_in  (key_map[5:0]),
        .rd_ok_in    (key_map[6]),                                     // [R14]
        .rd_data_out (key_rd_data),                                    // [R2]
        .a_we_in     (key_bus_we),
        .a_addr_in   (key_map[5:0]),
        .a_data_in   (hwdata_in[7:0]),
        .b_we_in     (key_capture_valid_in),
        .b_addr_in   ({`WEPL_CAPTURE_SLOT, capture_ptr}),
        .b_data_in   (key_capture_data_in)
    );
endmodule

//--- tb/wepl_ctrl_chk.sv
// Checker for the wake-event and power-loss register slice.
// Assumes the AHB-Lite slave port and the status pins of the top module.
`timescale 1ns/10ps
module wepl_ctrl_chk (
    input  wire        core_clk_in,
    input  wire        sys_rst_in,
    input  wire        hsel_in,
    input  wire [1:0]  htrans_in,
    input  wire        hready_in,
    input  wire [31:0] hrdata_out,
    input  wire        hreadyout_out,
    input  wire        hresp_out,
    input  wire        host_bus_reset_n_in,
    input  wire        power_return_in,
    input  wire        power_on_req_out,
    input  wire        kb_wake_any_key_out,
    input  wire        hunt_enable_out
);
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    property p_one_wait;
        hsel_in && htrans_in[1] && hready_in && hreadyout_out |=> !hreadyout_out ##1 hreadyout_out;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait state not one cycle");
    property p_okay;
        hresp_out == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_upper_zero;
        $changed(hrdata_out) |-> !$past(hreadyout_out) && hrdata_out[31:8] == 24'h000000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("bad read data update");
    // Host reset passes two sync flops before it clears the control bits
    property p_any_rst;
        !host_bus_reset_n_in [*3] |=> !kb_wake_any_key_out;
    endproperty
    a_any_rst: assert property (p_any_rst) else $error("any-key held in host reset");
    property p_hunt_rst;
        !host_bus_reset_n_in [*3] |=> !hunt_enable_out;
    endproperty
    a_hunt_rst: assert property (p_hunt_rst) else $error("hunt held in host reset");
    property p_any_src;
        $changed(kb_wake_any_key_out) |-> !$past(hreadyout_out) || !$past(host_bus_reset_n_in, 3);
    endproperty
    a_any_src: assert property (p_any_src) else $error("any-key changed without cause");
    property p_hunt_src;
        $rose(hunt_enable_out) |-> !$past(hreadyout_out);
    endproperty
    a_hunt_src: assert property (p_hunt_src) else $error("hunt set outside a write");
    property p_pulse_one;
        power_on_req_out |=> !power_on_req_out;
    endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("power-on pulse too long");
    property p_pwr_cause;
        $rose(power_on_req_out) |-> $past(power_return_in, 2);
    endproperty
    a_pwr_cause: assert property (p_pwr_cause) else $error("power-on without return");
endmodule

bind wepl_ctrl wepl_ctrl_chk wepl_ctrl_chk_i (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel_in),
    .htrans_in(htrans_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .host_bus_reset_n_in(host_bus_reset_n_in), .power_return_in(power_return_in),
    .power_on_req_out(power_on_req_out), .kb_wake_any_key_out(kb_wake_any_key_out),
    .hunt_enable_out(hunt_enable_out)
);

//--- tb/wepl_host_model.sv
// Host-side model: power sequencing pins, wake sources, key capture.
// Assumes the bench calls its tasks between clock edges.
`timescale 1ns/10ps
module wepl_host_model (
    input  wire       core_clk_in,
    output reg        host_bus_reset_n_out,
    output wire [5:0] event_out,
    output reg        prior_state_off_out,
    output reg        key_capture_valid_out,
    output reg  [7:0] key_capture_data_out
);
    // Event bits: kbd, mouse, switch, thermal, power return, standby
    reg [5:0] ev;
    assign event_out = ev;
    initial begin
        ev = 6'h00;
        host_bus_reset_n_out = 1'b1;
        prior_state_off_out = 1'b0;
        key_capture_valid_out = 1'b0;
        key_capture_data_out = 8'h00;
    end
    // Pins are async; held four high and three low so the sync sees both
    task pulse_event(input integer b);
        begin
            @(posedge core_clk_in) ev[b] <= 1'b1;
            repeat (4) @(posedge core_clk_in);
            ev[b] <= 1'b0;
            repeat (3) @(posedge core_clk_in);
        end
    endtask
    task host_reset;
        begin
            @(posedge core_clk_in) host_bus_reset_n_out <= 1'b0;
            repeat (4) @(posedge core_clk_in);
            host_bus_reset_n_out <= 1'b1;
            repeat (3) @(posedge core_clk_in);
        end
    endtask
    task set_prior(input reg v);
        @(posedge core_clk_in) prior_state_off_out <= v;
    endtask
    // One-cycle strobe, same clock as the slice
    task capture(input [7:0] d);
        begin
            @(posedge core_clk_in) key_capture_valid_out <= 1'b1;
            key_capture_data_out <= d;
            @(posedge core_clk_in) key_capture_valid_out <= 1'b0;
        end
    endtask
endmodule

//--- tb/tb.sv
// Self-checking bench for the wake-event and power-loss register slice.
// Assumes one AHB-Lite slave, hready looped back from hreadyout.
`timescale 1ns/10ps
`include "wepl_consts.vh"
module tb;
    reg         core_clk_in;
    reg         sys_rst_in;
    reg         hsel;
    reg  [31:0] haddr;
    reg  [1:0]  htrans;
    reg         hwrite;
    reg  [31:0] hwdata;
    wire [31:0] hrdata;
    wire        hready;
    wire        hn;
    wire [5:0]  ev;
    wire        prior;
    wire        cap_v;
    wire [7:0]  cap_d;
    wire        pwr_on;
    wire        any_key;
    wire        hunt;
    reg  [31:0] rdat;
    integer     error_cnt = 0, cmp_count = 0, cyc = 0, pulses = 0, k, m, p0;

    wepl_ctrl wepl_ctrl_i (
        .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(),
        .host_bus_reset_n_in(hn), .thermal_shutdown_in(ev[3]), .power_switch_input_in(ev[2]),
        .mouse_wake_in(ev[1]), .keyboard_wake_in(ev[0]), .standby_supply_event_in(ev[5]),
        .power_return_in(ev[4]), .prior_state_off_in(prior), .key_capture_valid_in(cap_v),
        .key_capture_data_in(cap_d), .power_on_req_out(pwr_on),
        .kb_wake_any_key_out(any_key), .hunt_enable_out(hunt));
    wepl_host_model wepl_host_model_i (
        .core_clk_in(core_clk_in), .host_bus_reset_n_out(hn), .event_out(ev),
        .prior_state_off_out(prior), .key_capture_valid_out(cap_v),
        .key_capture_data_out(cap_d));

    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end
    // Hang guard and power-on request counter
    always @(posedge core_clk_in) begin
        cyc = cyc + 1;
        if (pwr_on === 1'b1) pulses = pulses + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            $display("unexpected at %0t: run too long", $time);
            print_verdict;
        end
    end

    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", cmp_count, error_cnt);
            if (error_cnt == 0 && cmp_count > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task chk_reg(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("unexpected at %0t: read %h want %h", $time, got, exp);
            end
        end
    endtask
    task chk_bit(input got, input exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("unexpected at %0t: flag %b want %b", $time, got, exp);
            end
        end
    endtask
    // Single word transfer; holds each phase until hready is sampled high
    task ahb(input reg wr, input [31:0] a, input [31:0] wd);
        integer n;
        begin
            n = 0;
            @(posedge core_clk_in) hsel <= 1'b1;
            haddr <= a;
            htrans <= 2'h2;
            hwrite <= wr;
            @(posedge core_clk_in);
            while (hready !== 1'b1 && n < 50) begin
                n = n + 1;
                @(posedge core_clk_in);
            end
            htrans <= 2'h0;
            hwdata <= wd;
            @(posedge core_clk_in);
            while (hready !== 1'b1 && n < 50) begin
                n = n + 1;
                @(posedge core_clk_in);
            end
            rdat = hrdata;
            hsel <= 1'b0;
            if (n >= 50) chk_bit(1'b0, 1'b1);
        end
    endtask
    task rd_chk(input [31:0] a, input [31:0] exp);
        begin
            ahb(1'b0, a, 32'h0);
            chk_reg(rdat, exp);
        end
    endtask

    task t_reset;
        begin
            rd_chk(`WEPL_ADDR_KEY_DATA, 32'h0000_00ff);
            rd_chk(`WEPL_ADDR_STATUS, 32'h0000_0008);
            rd_chk(`WEPL_ADDR_STATUS, 32'h0000_0000);
            rd_chk(`WEPL_ADDR_CONTROL, 32'h0000_0000);
            rd_chk(32'h0000_0100, 32'h0000_0000);
            $display("test reset values done");
        end
    endtask
    // Both ends of every key set, then the capture area and a hole
    task t_keys;
        reg [7:0] ix [0:5];
        begin
            ix[0] = 8'h00; ix[1] = 8'h0e; ix[2] = 8'h30;
            ix[3] = 8'h3e; ix[4] = 8'h40; ix[5] = 8'h4e;
            for (k = 0; k < 6; k = k + 1) begin
                ahb(1'b1, `WEPL_ADDR_KEY_INDEX, {24'h0, ix[k]});
                ahb(1'b1, `WEPL_ADDR_KEY_DATA, {24'h0, ix[k] ^ 8'h5a});
            end
            for (k = 0; k < 6; k = k + 1) begin
                ahb(1'b1, `WEPL_ADDR_KEY_INDEX, {24'h0, ix[k]});
                rd_chk(`WEPL_ADDR_KEY_DATA, {24'h0, ix[k] ^ 8'h5a});
            end
            ahb(1'b1, `WEPL_ADDR_KEY_INDEX, 32'h0000_0010);
            ahb(1'b1, `WEPL_ADDR_KEY_DATA, 32'h0000_0033);
            wepl_host_model_i.capture(8'h77);
            rd_chk(`WEPL_ADDR_KEY_DATA, 32'h0000_0077);
            ahb(1'b1, `WEPL_ADDR_KEY_INDEX, 32'h0000_000f);
            rd_chk(`WEPL_ADDR_KEY_DATA, 32'h0000_00ff);
            $display("test key window done");
        end
    endtask
    task t_status;
        begin
            for (k = 0; k < 6; k = k + 1) begin
                if (k != 4) begin
                    wepl_host_model_i.pulse_event(k);
                    rd_chk(`WEPL_ADDR_STATUS, 32'h1 << k);
                    rd_chk(`WEPL_ADDR_STATUS, 32'h0);
                end
            end
            $display("test status flags done");
        end
    endtask
    task t_hunt;
        begin
            ahb(1'b1, `WEPL_ADDR_CONTROL, 32'h0000_00ff);
            rd_chk(`WEPL_ADDR_CONTROL, 32'h0000_006c);
            chk_bit(any_key, 1'b1);
            chk_bit(hunt, 1'b1);
            wepl_host_model_i.pulse_event(0);
            chk_bit(hunt, 1'b0);
            rd_chk(`WEPL_ADDR_STATUS, 32'h1);
            ahb(1'b1, `WEPL_ADDR_CONTROL, 32'h0000_006c);
            wepl_host_model_i.host_reset;
            chk_bit(any_key, 1'b0);
            chk_bit(hunt, 1'b0);
            rd_chk(`WEPL_ADDR_CONTROL, 32'h0000_0060);
            $display("test wake options done");
        end
    endtask
    // Every recovery mode; case 1 leaves the loss report disabled
    task t_recovery;
        reg on;
        begin
            for (k = 0; k < 8; k = k + 1) begin
                m = k >> 1;
                on = (m == 1) || (m == 2 && k[0] == 0) || (m == 3 && k[0] == 1);
                wepl_host_model_i.set_prior(k[0]);
                ahb(1'b1, `WEPL_ADDR_LAST_STATE, {27'h0, ~k[0], 4'h0});
                rd_chk(`WEPL_ADDR_LAST_STATE, {27'h0, ~k[0], 4'h0});
                ahb(1'b1, `WEPL_ADDR_CONTROL, {24'h0, k != 1, m[1:0], 5'h0});
                p0 = pulses;
                wepl_host_model_i.pulse_event(4);
                chk_reg(pulses - p0, on);
                rd_chk(`WEPL_ADDR_STATUS, (!on && k != 1) ? 32'h10 : 32'h0);
            end
            $display("test power-loss recovery done");
        end
    endtask

    initial begin
        sys_rst_in = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (3) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        t_reset;
        t_keys;
        t_status;
        t_hunt;
        t_recovery;
        print_verdict;
    end
endmodule
